// *** src/acc_pkg.sv ***
// constants and types shared by the conversion control block
`default_nettype none
package acc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register offsets and reset value
  localparam logic [7:0] ACC_OFF_RES_LO = 8'h19;
  localparam logic [7:0] ACC_OFF_RES_HI = 8'h1a;
  localparam logic [7:0] ACC_OFF_SEL    = 8'h1b;
  localparam logic [7:0] ACC_OFF_TRIG   = 8'h1c;
  localparam logic [7:0] ACC_OFF_CTRL   = 8'h1d;
  localparam logic [7:0] ACC_REG_RESET  = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ACC_CTRL_ON    = 7;
  localparam int ACC_CTRL_GO    = 6;
  localparam int ACC_CTRL_AUTO  = 5;
  localparam int ACC_CTRL_FLAG  = 4;
  localparam int ACC_CTRL_IRQ   = 3;
  localparam int ACC_CTRL_DIV   = 0;
  localparam int ACC_SEL_REF    = 6;
  localparam int ACC_SEL_CHAN   = 0;
  localparam int ACC_TRIG_LEFT  = 7;
  localparam int ACC_TRIG_SRC   = 0;
  ////////////////////////////////////////////////////////////////////////////
  // conversion lengths in converter clocks, and special codes
  localparam logic [4:0] ACC_FIRST_LEN = 5'd25;
  localparam logic [4:0] ACC_NORM_LEN  = 5'd13;
  localparam logic [2:0] ACC_SRC_FREE  = 3'h0;
  localparam logic [6:0] ACC_DIV_MIN   = 7'h01;
  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic {ACC_IDLE, ACC_CONVERT} acc_conv_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acc_bus_t;
  typedef struct packed {
    logic       on;
    logic       busy;
    logic       first;
    logic       start;
    logic [1:0] ref_sel;
    logic [2:0] chan_sel;
  } acc_conv_out_t;
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } acc_pre_state_t;
  typedef struct packed {
    acc_conv_t  conv;
    logic       busy;
    logic       on;
    logic       auto_on;
    logic       flag;
    logic       irq_on;
    logic [2:0] div;
    logic [1:0] ref_req;
    logic [2:0] chan_req;
    logic       left;
    logic [2:0] src;
    logic [1:0] ref_act;
    logic [2:0] chan_act;
    logic [9:0] result;
    logic       lock;
    logic       first;
    logic [4:0] cnt;
    logic       src_prev;
    logic [7:0] rdata;
    logic       irq;
    logic       start;
    logic       done;
  } acc_state_t;
endpackage : acc_pkg
`default_nettype wire

// *** src/acc_prescaler.sv ***
// converter clock prescaler: one-cycle tick per converter clock
`default_nettype none
module acc_prescaler (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] div_sel,
  // converter clock tick
  output logic            tick
);
  import acc_pkg::*;

  acc_pre_state_t st_r;
  acc_pre_state_t st_nxt;

  // last count of one converter clock period
  function automatic logic [6:0] acc_last(input logic [2:0] sel);
    logic [7:0] div;
    div = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
    return div[6:0] - ACC_DIV_MIN;
  endfunction : acc_last

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run || restart) begin
      st_nxt.cnt = 7'h00;
    // divide ratio; >= copes with a smaller divisor written mid-count
    end else if (st_r.cnt >= acc_last(div_sel)) begin
      st_nxt.cnt  = 7'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

  ////////////////////////////////////////////////////////////////////////////
  a_div_ratio: assert property (@(posedge clock) disable iff (rst)
    (run && !restart && st_r.cnt == acc_last(div_sel)) |=> tick)
    else $error("prescaler tick missing at end of period");

  a_restart_clears: assert property (@(posedge clock) disable iff (rst)
    restart |=> (st_r.cnt == 7'h00 && !tick))
    else $error("prescaler not cleared by restart");

endmodule : acc_prescaler
`default_nettype wire

// *** src/acc_top.sv ***
// conversion control and result registers of a 10-bit converter
`default_nettype none
module acc_top (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // register port
  input  wire acc_pkg::acc_bus_t     bus,
  output logic [7:0]                 reg_rdata,
  // trigger sources, codes 1 to 7
  input  wire logic [7:1]            trig_flags,
  // interrupt
  input  wire logic                  global_irq_on,
  input  wire logic                  vector_taken,
  output logic                       irq_req,
  // converter
  input  wire logic [9:0]            sar_code,
  output acc_pkg::acc_conv_out_t     conv,
  output logic                       conv_tick
);
  import acc_pkg::*;

  acc_state_t st_r;
  acc_state_t st_nxt;
  logic       trig_lvl;
  logic       trig_edge;
  logic       go_wr;
  logic       lo_read;
  logic       hi_read;
  logic       restart;
  logic       tick;
  logic [4:0] conv_len;

  ////////////////////////////////////////////////////////////////////////////
  // source select; free running has no source level
  // level zero for free running, so switching there makes no edge
  assign trig_lvl  = (st_r.src == ACC_SRC_FREE) ? 1'b0 : trig_flags[st_r.src];
  // compared with last cycle's registered level
  assign trig_edge = st_r.auto_on && trig_lvl && !st_r.src_prev;
  assign go_wr     = bus.wr && bus.addr == ACC_OFF_CTRL && bus.wdata[ACC_CTRL_GO];
  assign lo_read   = bus.rd && bus.addr == ACC_OFF_RES_LO;
  assign hi_read   = bus.rd && bus.addr == ACC_OFF_RES_HI;
  // trigger resets the prescaler for a fixed sampling delay
  assign restart   = (trig_edge && st_r.conv == ACC_IDLE) || !st_r.on;
  // first conversion after enable is the long one
  assign conv_len  = st_r.first ? ACC_FIRST_LEN : ACC_NORM_LEN;

  acc_prescaler u_pre (
    .clock   (clock),
    .rst     (rst),
    .run     (st_r.on),
    .restart (restart),
    .div_sel (st_r.div),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt          = st_r;
    st_nxt.start    = 1'b0;
    st_nxt.done     = 1'b0;
    st_nxt.rdata    = 8'h00;
    st_nxt.src_prev = trig_lvl;
    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        ACC_OFF_CTRL: begin
          st_nxt.on      = bus.wdata[ACC_CTRL_ON];
          st_nxt.auto_on = bus.wdata[ACC_CTRL_AUTO];
          st_nxt.irq_on  = bus.wdata[ACC_CTRL_IRQ];
          st_nxt.div     = bus.wdata[ACC_CTRL_DIV +: 3];
          if (bus.wdata[ACC_CTRL_FLAG]) begin
            st_nxt.flag = 1'b0;
          end
        end
        ACC_OFF_SEL: begin
          // reference code goes to the converter unchanged
          st_nxt.ref_req  = bus.wdata[ACC_SEL_REF +: 2];
          st_nxt.chan_req = bus.wdata[ACC_SEL_CHAN +: 3];
        end
        ACC_OFF_TRIG: begin
          st_nxt.left = bus.wdata[ACC_TRIG_LEFT];
          st_nxt.src  = bus.wdata[ACC_TRIG_SRC +: 3];
        end
        default: begin
        end
      endcase
    end
    // enabling, even with start in the same write, arms the long one
    if (!st_r.on && st_nxt.on) begin
      st_nxt.first = 1'b1;
    end
    if (vector_taken) begin
      st_nxt.flag = 1'b0;
    end
    // low read locks, high read unlocks
    if (lo_read) begin
      st_nxt.lock = 1'b1;
    end else if (hi_read) begin
      st_nxt.lock = 1'b0;
    end
    // conversion sequence
    unique case (st_r.conv)
      ACC_IDLE: begin
        st_nxt.ref_act  = st_nxt.ref_req;
        st_nxt.chan_act = st_nxt.chan_req;
        if (st_nxt.on && (go_wr || trig_edge)) begin
          st_nxt.conv  = ACC_CONVERT;
          st_nxt.cnt   = 5'h00;
          st_nxt.start = 1'b1;
        end
      end
      ACC_CONVERT: begin
        if (tick) begin
          if (st_r.cnt == conv_len - 5'h01) begin
            st_nxt.done = 1'b1;
            // set after clears, so a same-cycle clear loses
            st_nxt.flag = 1'b1;
            if (!st_r.lock && !lo_read) begin
              st_nxt.result = sar_code;
            end
            st_nxt.first    = 1'b0;
            st_nxt.ref_act  = st_nxt.ref_req;
            st_nxt.chan_act = st_nxt.chan_req;
            st_nxt.cnt      = 5'h00;
            // free running goes straight into the next one
            if (st_r.auto_on && st_r.src == ACC_SRC_FREE) begin
              st_nxt.start = 1'b1;
            end else begin
              st_nxt.conv = ACC_IDLE;
            end
          end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
        end
      end
    endcase
    if (!st_nxt.on) begin
      st_nxt.conv  = ACC_IDLE;
      st_nxt.cnt   = 5'h00;
      st_nxt.start = 1'b0;
    end
    st_nxt.busy = (st_nxt.conv == ACC_CONVERT);
    // register reads, data one cycle later
    if (bus.rd) begin
      unique case (bus.addr)
        // readout layout follows left adjust at once
        ACC_OFF_RES_LO: st_nxt.rdata = st_r.left ? {st_r.result[1:0], 6'h00} : st_r.result[7:0];
        ACC_OFF_RES_HI: st_nxt.rdata = st_r.left ? st_r.result[9:2] : {6'h00, st_r.result[9:8]};
        ACC_OFF_SEL:    st_nxt.rdata = {st_r.ref_req, 3'h0, st_r.chan_req};
        ACC_OFF_TRIG:   st_nxt.rdata = {st_r.left, 4'h0, st_r.src};
        ACC_OFF_CTRL:   st_nxt.rdata = {st_r.on, st_r.busy, st_r.auto_on, st_r.flag, st_r.irq_on, st_r.div};
        default:        st_nxt.rdata = 8'h00;
      endcase
    end
    // request while flag and both enables set
    st_nxt.irq = st_nxt.flag && st_nxt.irq_on && global_irq_on;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata     = st_r.rdata;
  assign irq_req       = st_r.irq;
  assign conv_tick     = tick;
  assign conv.on       = st_r.on;
  assign conv.busy     = st_r.busy;
  assign conv.first    = st_r.first;
  assign conv.start    = st_r.start;
  assign conv.ref_sel  = st_r.ref_act;
  assign conv.chan_sel = st_r.chan_act;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_result_locked: assert property (
    (st_r.lock && !hi_read) |=> $stable(st_r.result))
    else $error("result changed while locked");

  a_high_layout: assert property (
    (hi_read && !st_r.left) |=> (reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(st_r.result[9:8])))
    else $error("right adjusted high byte wrong");

  a_ref_held: assert property (
    (st_r.busy && $past(st_r.busy) && !st_r.done) |-> $stable(conv.ref_sel))
    else $error("reference changed mid conversion");

  a_chan_held: assert property (
    (st_r.busy && $past(st_r.busy) && !st_r.done) |-> $stable(conv.chan_sel))
    else $error("channel changed mid conversion");

  a_off_aborts: assert property (
    (bus.wr && bus.addr == ACC_OFF_CTRL && !bus.wdata[ACC_CTRL_ON]) |=> (!conv.busy && !conv.on))
    else $error("disable did not abort");

  a_conv_length: assert property (
    st_r.done |-> ($past(st_r.cnt) == ($past(st_r.first) ? ACC_FIRST_LEN : ACC_NORM_LEN) - 5'h01))
    else $error("conversion length wrong");

  a_go_readback: assert property (
    (bus.rd && bus.addr == ACC_OFF_CTRL) |=> (reg_rdata[ACC_CTRL_GO] == $past(st_r.busy)))
    else $error("start bit does not show busy");

  a_trig_starts: assert property (
    (trig_edge && st_r.on && !st_r.busy) |=> (conv.busy && conv.start))
    else $error("trigger edge did not start");

  a_flag_on_done: assert property (
    st_r.done |-> st_r.flag ##1 (st_r.flag || $past(vector_taken) || $past(bus.wr)))
    else $error("flag not set at completion");

  a_vector_clears: assert property (
    (vector_taken && !(st_r.busy && tick)) |=> !st_r.flag)
    else $error("vector did not clear flag");

  a_irq_request: assert property (
    (st_r.flag && st_r.irq_on && global_irq_on && !vector_taken && !bus.wr) |=> irq_req)
    else $error("interrupt request missing");

  a_irq_masked: assert property (
    !global_irq_on |=> !irq_req)
    else $error("interrupt request without global enable");

  a_low_layout: assert property (
    (lo_read && !st_r.left) |=> (reg_rdata == $past(st_r.result[7:0])))
    else $error("right adjusted low byte wrong");

  a_left_high: assert property (
    (hi_read && st_r.left) |=> (reg_rdata == $past(st_r.result[9:2])))
    else $error("left adjusted high byte wrong");

  a_ref_follows: assert property (
    (st_r.conv == ACC_IDLE) |=> (conv.ref_sel == st_r.ref_req))
    else $error("reference code not passed on while idle");

  a_chan_follows: assert property (
    (st_r.conv == ACC_IDLE) |=> (conv.chan_sel == st_r.chan_req))
    else $error("channel code not passed on while idle");

  a_go_starts: assert property (
    (go_wr && bus.wdata[ACC_CTRL_ON] && !st_r.busy) |=> (conv.busy && conv.start))
    else $error("start write did not begin a conversion");

  a_first_armed: assert property (
    (bus.wr && bus.addr == ACC_OFF_CTRL && bus.wdata[ACC_CTRL_ON] && !st_r.on) |=> conv.first)
    else $error("enabling did not arm the long conversion");

  a_zero_go: assert property (
    (bus.wr && bus.addr == ACC_OFF_CTRL && !bus.wdata[ACC_CTRL_GO] && !st_r.busy && !trig_edge) |=> !conv.busy)
    else $error("zero start write began a conversion");

  a_result_update: assert property (
    (st_r.busy && tick && st_r.cnt == conv_len - 5'h01 && !st_r.lock && !lo_read)
    |=> (st_r.result == $past(sar_code)))
    else $error("result not taken at completion");

  a_free_restart: assert property (
    (st_r.busy && tick && st_r.cnt == conv_len - 5'h01 && st_r.auto_on && st_r.src == ACC_SRC_FREE && !bus.wr)
    |=> (conv.busy && conv.start))
    else $error("free running did not restart");

endmodule : acc_top
`default_nettype wire

// *** tb/acc_sar_model.sv ***
// behavioural combinational converter model facing the conversion control
`default_nettype none
module acc_sar_model (
  // converter side
  input  wire acc_pkg::acc_conv_out_t conv,
  output logic [9:0]                  sar_code
);
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // unsigned code built from the live reference and channel
  always_comb begin
    sar_code = {conv.ref_sel, 4'ha, 1'b0, conv.chan_sel};
    // outside a conversion the value is meaningless, so show the inverse
    if (conv.busy !== 1'b1) begin
      sar_code = ~sar_code;
    end
  end
endmodule : acc_sar_model
`default_nettype wire

// *** tb/adc_conversion_control_test.sv ***
// self-checking testbench of the conversion control block
`default_nettype none
module adc_conversion_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;
  logic          clock;
  logic          rst;
  acc_bus_t      bus;
  logic [7:0]    reg_rdata;
  logic [7:1]    trig_flags;
  logic          global_irq_on;
  logic          vector_taken;
  logic          irq_req;
  logic [9:0]    sar_code;
  logic [9:0]    r;
  acc_conv_out_t conv;
  logic          conv_tick;
  int            error_cnt;
  int            n_tests;
  int            n;
  ////////////////////////////////////////////////////////////////////////////
  acc_top u_dut (
    .clock         (clock),
    .rst           (rst),
    .bus           (bus),
    .reg_rdata     (reg_rdata),
    .trig_flags    (trig_flags),
    .global_irq_on (global_irq_on),
    .vector_taken  (vector_taken),
    .irq_req       (irq_req),
    .sar_code      (sar_code),
    .conv          (conv),
    .conv_tick     (conv_tick)
  );
  acc_sar_model u_sar (
    .conv     (conv),
    .sar_code (sar_code)
  );
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] code_of(input logic [1:0] rf, input logic [2:0] ch);
    return {rf, 4'ha, 1'b0, ch};
  endfunction : code_of
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 chk({2'h0, reg_rdata}, {2'h0, e});
  endtask : rd
  // counts converter ticks of one conversion and the spacing of the last two
  task automatic conv_run(input int n_tick, input int gap);
    int t;
    int last;
    int g;
    int k;
    t = 0;
    last = 0;
    g = 0;
    for (k = 0; k < 4000 && (k < 3 || conv.busy === 1'b1); k++) begin
      @(posedge clock);
      #1;
      if (conv_tick === 1'b1 && conv.busy === 1'b1) begin
        t++;
        g = k - last;
        last = k;
      end
    end
    if (k == 4000) begin
      $display("mismatch at %0t: conversion did not end", $time);
      error_cnt++;
      tally_and_finish();
    end
    chk(10'(t), 10'(n_tick));
    chk(10'(g), 10'(gap));
  endtask : conv_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bus = '0;
    trig_flags = '0;
    global_irq_on = 1'b1;
    vector_taken = 1'b0;
    rst = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int a = 8'h19; a <= 8'h1e; a++) rd(a[7:0], 8'h00);
    wr(ACC_OFF_SEL, 8'h85);
    wr(ACC_OFF_CTRL, 8'hc8);
    #1 chk(conv.first, 1'b1);
    fork
      conv_run(25, 2);
      begin
        wr(ACC_OFF_SEL, 8'h03);
        #1 chk(conv.chan_sel, 3'h5);
        chk(conv.ref_sel, 2'h2);
        rd(ACC_OFF_CTRL, 8'hc8);
      end
    join
    r = code_of(2'h2, 3'h5);
    rd(ACC_OFF_CTRL, 8'h98);
    chk(irq_req, 1'b1);
    chk(conv.chan_sel, 3'h3);
    @(posedge clock);
    global_irq_on <= 1'b0;
    @(posedge clock);
    #1 chk(irq_req, 1'b0);
    @(posedge clock);
    global_irq_on <= 1'b1;
    @(posedge clock);
    #1 chk(irq_req, 1'b1);
    rd(ACC_OFF_RES_LO, r[7:0]);
    rd(ACC_OFF_RES_HI, {6'h00, r[9:8]});
    @(posedge clock);
    vector_taken <= 1'b1;
    @(posedge clock);
    vector_taken <= 1'b0;
    rd(ACC_OFF_CTRL, 8'h88);
    chk(irq_req, 1'b0);
    // low byte read locks the pair across a whole conversion
    rd(ACC_OFF_RES_LO, r[7:0]);
    wr(ACC_OFF_CTRL, 8'hcb);
    conv_run(13, 8);
    rd(ACC_OFF_CTRL, 8'h9b);
    rd(ACC_OFF_RES_HI, {6'h00, r[9:8]});
    wr(ACC_OFF_CTRL, 8'hdb);
    conv_run(13, 8);
    r = code_of(2'h0, 3'h3);
    wr(ACC_OFF_TRIG, 8'h80);
    rd(ACC_OFF_RES_HI, r[9:2]);
    rd(ACC_OFF_RES_LO, {r[1:0], 6'h00});
    wr(ACC_OFF_CTRL, 8'h83);
    repeat (4) @(posedge clock);
    #1 chk(conv.busy, 1'b0);
    wr(ACC_OFF_CTRL, 8'hc3);
    repeat (5) @(posedge clock);
    wr(ACC_OFF_CTRL, 8'h00);
    #1 chk(conv.busy, 1'b0);
    chk(conv.on, 1'b0);
    repeat (3) @(posedge clock);
    #1 chk(conv_tick, 1'b0);
    wr(ACC_OFF_CTRL, 8'ha0);
    for (int s = 1; s < 8; s++) begin
      wr(ACC_OFF_TRIG, 8'(s));
      @(posedge clock);
      trig_flags <= 7'(1 << (s - 1));
      conv_run(s == 1 ? 25 : 13, 2);
      @(posedge clock);
      trig_flags <= '0;
    end
    // switch to free running while the flag is still set
    wr(ACC_OFF_TRIG, 8'h00);
    repeat (6) @(posedge clock);
    #1 chk(conv.busy, 1'b0);
    wr(ACC_OFF_CTRL, 8'he0);
    n = 0;
    repeat (100) begin
      @(posedge clock);
      #1;
      if (conv.start === 1'b1) n++;
    end
    chk(n >= 3, 1'b1);
    chk(conv.busy, 1'b1);
    wr(ACC_OFF_CTRL, 8'h00);
    tally_and_finish();
  end
endmodule : adc_conversion_control_test
`default_nettype wire
